// [rtl/vdcr_consts.svh]
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the register bank sources
`ifndef VDCR_CONSTS_SVH
`define VDCR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VDCR_OFS_CHROMA_DEF  8'h0d
`define VDCR_OFS_MAP_SEL     8'h0e
`define VDCR_OFS_PWR_RST     8'h0f
`define VDCR_OFS_LOCK_STAT   8'h10
`define VDCR_OFS_REV_ID      8'h11
`define VDCR_OFS_PROT_STAT   8'h12
`define VDCR_OFS_SYNC_STAT   8'h13
`define VDCR_OFS_CLAMP_PAT   8'h14
`define VDCR_OFS_DCLAMP      8'h15
`define VDCR_OFS_SHAPE       8'h17
`define VDCR_OFS_WIDE        8'h18
`define VDCR_OFS_COMB        8'h19
`define VDCR_OFS_PCLK_PIN    8'h1d
`define VDCR_OFS_DELAY       8'h27

// ----------------------------------------------------------------
// Reset values and writable bit masks
// ----------------------------------------------------------------
`define VDCR_RST_CHROMA_DEF  8'h7c
`define VDCR_RST_MAP_SEL     8'h00
`define VDCR_RST_PWR_RST     8'h00
`define VDCR_RST_CLAMP_PAT   8'h10
`define VDCR_RST_DCLAMP      8'h00
`define VDCR_RST_SHAPE       8'h01
`define VDCR_RST_WIDE        8'h93
`define VDCR_RST_COMB        8'hf1
`define VDCR_RST_PCLK_PIN    8'h40
`define VDCR_RST_DELAY       8'h58
`define VDCR_MSK_CHROMA_DEF  8'hff
`define VDCR_MSK_MAP_SEL     8'h60
`define VDCR_MSK_PWR_RST     8'h20
`define VDCR_MSK_CLAMP_PAT   8'h17
`define VDCR_MSK_DCLAMP      8'h70
`define VDCR_MSK_SHAPE       8'hff
`define VDCR_MSK_WIDE        8'h9f
`define VDCR_MSK_COMB        8'h0f
`define VDCR_MSK_PCLK_PIN    8'h80
`define VDCR_MSK_DELAY       8'h7b

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VDCR_BIT_SOFT_RESET  7
`define VDCR_BIT_POWER_DOWN  5
`define VDCR_BIT_AUTO_ALIGN  6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VDCR_CLK_PERIOD_NS   10
`define VDCR_SRST_TIME_US    2000
`define VDCR_SRST_CYCLES ((`VDCR_SRST_TIME_US * 1000) / `VDCR_CLK_PERIOD_NS)

`endif

// [rtl/vdcr_pkg.sv]
// Types shared by the video decoder control register bank
// Assumes the consts header for offsets and reset values; state codes are set here
package vdcr_pkg;

  // ----------------------------------------------------------------
  // Decoder status fed in from the datapath
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       in_lock;
    logic       subcarrier_lock;
    logic       peak_white_gain_active;
    logic [2:0] standard;
    logic       color_kill;
    logic       stripe_detected;
    logic       stripe_type;
    logic       pseudosync_detected;
    logic       agc_pulse_detected;
    logic       odd_line_length;
    logic       odd_subcarrier;
    logic       raw_horizontal_lock;
    logic       field_rate_fifty;
    logic       free_run_active;
    logic       field_length_ok;
    logic       interlaced;
    logic       swinging_burst_lock;
  } vdcr_status_s;

  // ----------------------------------------------------------------
  // Controls driven to the decoder
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] default_cr;
    logic [3:0] default_cb;
    logic [1:0] submap_select;
    logic       power_down_bit;
    logic [2:0] free_run_pattern;
    logic       current_clamp_on;
    logic       digital_clamp_freeze;
    logic [1:0] digital_clamp_speed;
    logic [4:0] luma_shape_filter;
    logic [2:0] chroma_shape_filter;
    logic [4:0] wide_luma_filter;
    logic       wide_filter_manual;
    logic [1:0] pal_comb_bandwidth;
    logic [1:0] ntsc_comb_bandwidth;
    logic       llc_tristate;
    logic       auto_delay_align;
  } vdcr_ctrl_s;

  typedef enum logic [2:0] {
    VDCR_ST_IDLE = 3'h0,
    VDCR_ST_ADDR = 3'h1,
    VDCR_ST_ACK  = 3'h3,
    VDCR_ST_WR   = 3'h2,
    VDCR_ST_RD   = 3'h6,
    VDCR_ST_RACK = 3'h7
  } vdcr_state_e;

  typedef logic [9:0][7:0] vdcr_regs_t;

  typedef struct packed {
    logic [2:0]  scl_sync;
    logic [2:0]  sda_sync;
    vdcr_state_e st;
    logic        rw;
    logic        first;
    logic [7:0]  ptr;
    logic [7:0]  sh;
    logic [3:0]  cnt;
    logic        sda_oe;
    vdcr_regs_t  regs;
    logic        lost_lock;
    logic        lock_prev;
    logic        srst_busy;
    logic [17:0] srst_cnt;
    logic [1:0]  luma_delay;
    logic [2:0]  chroma_delay;
  } vdcr_q_s;

endpackage

// [rtl/vdcr_top.sv]
// Control and status register bank of a video decoder on a 2-wire port
// Assumes open-drain bus resolved outside; status comes from clk_i logic
`timescale 1ns/1ps
`include "vdcr_consts.svh"

module vdcr_top #(
  parameter logic [6:0] DEV_ADDR    = 7'h20,
  parameter logic [7:0] REV_ID      = 8'h5a,
  parameter int         SRST_CYCLES = `VDCR_SRST_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // Two-wire control port
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  // Decoder side
  input  wire vdcr_pkg::vdcr_status_s status_i,
  input  wire logic [1:0]            input_format_i,
  output vdcr_pkg::vdcr_ctrl_s       ctrl_o,
  output logic [1:0]                 luma_delay_o,
  output logic [2:0]                 chroma_delay_o,
  output logic                       soft_reset_busy_o
);

  // ----------------------------------------------------------------
  // Register table
  // ----------------------------------------------------------------
  localparam logic [9:0][7:0] OFS = {
    `VDCR_OFS_DELAY, `VDCR_OFS_PCLK_PIN, `VDCR_OFS_COMB, `VDCR_OFS_WIDE,
    `VDCR_OFS_SHAPE, `VDCR_OFS_DCLAMP, `VDCR_OFS_CLAMP_PAT,
    `VDCR_OFS_PWR_RST, `VDCR_OFS_MAP_SEL, `VDCR_OFS_CHROMA_DEF};
  localparam logic [9:0][7:0] RST = {
    `VDCR_RST_DELAY, `VDCR_RST_PCLK_PIN, `VDCR_RST_COMB, `VDCR_RST_WIDE,
    `VDCR_RST_SHAPE, `VDCR_RST_DCLAMP, `VDCR_RST_CLAMP_PAT,
    `VDCR_RST_PWR_RST, `VDCR_RST_MAP_SEL, `VDCR_RST_CHROMA_DEF};
  localparam logic [9:0][7:0] MSK = {
    `VDCR_MSK_DELAY, `VDCR_MSK_PCLK_PIN, `VDCR_MSK_COMB, `VDCR_MSK_WIDE,
    `VDCR_MSK_SHAPE, `VDCR_MSK_DCLAMP, `VDCR_MSK_CLAMP_PAT,
    `VDCR_MSK_PWR_RST, `VDCR_MSK_MAP_SEL, `VDCR_MSK_CHROMA_DEF};
  localparam logic [17:0] SRST_LAST = 18'(SRST_CYCLES - 1);
  localparam int          S_CHR = 0;
  localparam int          S_MAP = 1;
  localparam int          S_PWR = 2;
  localparam int          S_CLP = 3;
  localparam int          S_DCL = 4;
  localparam int          S_SHP = 5;
  localparam int          S_WID = 6;
  localparam int          S_CMB = 7;
  localparam int          S_PIN = 8;
  localparam int          S_DLY = 9;

  vdcr_pkg::vdcr_q_s q;
  vdcr_pkg::vdcr_q_s d;
  logic              scl_rise;
  logic              scl_fall;
  logic              bus_start;
  logic              bus_stop;
  logic              sda_s;
  logic              main_map;
  logic              rd_load;
  logic              wr_en;
  logic [7:0]        rd_data;
  logic [7:0]        wr_addr;

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  // Stage 0 only feeds stage 1; edges use stages 1 and 2
  assign sda_s     = q.sda_sync[1];
  assign scl_rise  = q.scl_sync[1] & ~q.scl_sync[2];
  assign scl_fall  = ~q.scl_sync[1] & q.scl_sync[2];
  assign bus_start = q.scl_sync[1] & ~q.sda_sync[1] & q.sda_sync[2];
  assign bus_stop  = q.scl_sync[1] & q.sda_sync[1] & ~q.sda_sync[2];
  // Other maps live elsewhere; only page select answers in all maps
  assign main_map  = (q.regs[S_MAP][6:5] == 2'h0);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input vdcr_pkg::vdcr_q_s s,
                                          input vdcr_pkg::vdcr_status_s st);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `VDCR_OFS_LOCK_STAT:
        r = {st.color_kill, st.standard, st.peak_white_gain_active,
             st.subcarrier_lock, s.lost_lock, st.in_lock};
      `VDCR_OFS_REV_ID:
        r = REV_ID;
      `VDCR_OFS_PROT_STAT:
        r = {2'h0, st.odd_subcarrier, st.odd_line_length,
             st.agc_pulse_detected, st.pseudosync_detected,
             st.stripe_type, st.stripe_detected};
      `VDCR_OFS_SYNC_STAT:
        r = {st.swinging_burst_lock, st.interlaced, st.field_length_ok,
             st.free_run_active, 1'b0, st.field_rate_fifty, 1'b0,
             st.raw_horizontal_lock};
      `VDCR_OFS_PWR_RST:
        r = {s.srst_busy, s.regs[S_PWR][6:0]};
      default:
      begin
        for (int i = 0; i < 10; i++)
        begin
          if (a == OFS[i])
          begin
            r = s.regs[i];
          end
        end
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d        = q;
    rd_load  = 1'b0;
    wr_en    = 1'b0;
    wr_addr  = q.ptr;
    rd_data  = 8'h00;
    d.scl_sync = {q.scl_sync[1:0], scl_i};
    d.sda_sync = {q.sda_sync[1:0], sda_i};
    if (bus_start)
    begin
      d.st     = vdcr_pkg::VDCR_ST_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      d.st     = vdcr_pkg::VDCR_ST_IDLE;
      d.sda_oe = 1'b0;
    end
    else
    begin
      unique case (q.st)
        vdcr_pkg::VDCR_ST_IDLE:
        begin
          d.sda_oe = 1'b0;
        end
        vdcr_pkg::VDCR_ST_ADDR, vdcr_pkg::VDCR_ST_WR:
        begin
          if (scl_rise && q.cnt != 4'h8)
          begin
            d.sh  = {q.sh[6:0], sda_s};
            d.cnt = q.cnt + 4'h1;
          end
          else if (scl_fall && q.cnt == 4'h8)
          begin
            d.cnt = 4'h0;
            if (q.st == vdcr_pkg::VDCR_ST_ADDR)
            begin
              if (q.sh[7:1] == DEV_ADDR)
              begin
                d.rw     = q.sh[0];
                d.first  = ~q.sh[0];
                d.sda_oe = 1'b1;
                d.st     = vdcr_pkg::VDCR_ST_ACK;
              end
              else
              begin
                d.st = vdcr_pkg::VDCR_ST_IDLE;
              end
            end
            else
            begin
              if (q.first)
              begin
                d.ptr   = q.sh;
                d.first = 1'b0;
              end
              else
              begin
                wr_en = 1'b1;
                d.ptr = q.ptr + 8'h01;
              end
              d.sda_oe = 1'b1;
              d.st     = vdcr_pkg::VDCR_ST_ACK;
            end
          end
        end
        vdcr_pkg::VDCR_ST_ACK, vdcr_pkg::VDCR_ST_RACK:
        begin
          if (q.st == vdcr_pkg::VDCR_ST_RACK && scl_rise && sda_s)
          begin
            d.st = vdcr_pkg::VDCR_ST_IDLE;
          end
          else if (scl_fall)
          begin
            d.cnt = 4'h0;
            if (q.rw)
            begin
              rd_load  = 1'b1;
              rd_data  = (main_map || q.ptr == `VDCR_OFS_MAP_SEL) ?
                         read_reg(q.ptr, q, status_i) : 8'h00;
              d.sh     = rd_data;
              d.ptr    = q.ptr + 8'h01;
              d.sda_oe = ~rd_data[7];
              d.st     = vdcr_pkg::VDCR_ST_RD;
            end
            else
            begin
              d.sda_oe = 1'b0;
              d.st     = vdcr_pkg::VDCR_ST_WR;
            end
          end
        end
        vdcr_pkg::VDCR_ST_RD:
        begin
          if (scl_rise)
          begin
            d.cnt = q.cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (q.cnt == 4'h8)
            begin
              d.sda_oe = 1'b0;
              d.st     = vdcr_pkg::VDCR_ST_RACK;
            end
            else
            begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
      endcase
    end

    // Register writes, blocked while the reset sequence runs
    if (wr_en && !q.srst_busy &&
        (main_map || wr_addr == `VDCR_OFS_MAP_SEL))
    begin
      for (int i = 0; i < 10; i++)
      begin
        if (wr_addr == OFS[i])
        begin
          d.regs[i] = (q.regs[i] & ~MSK[i]) | (q.sh & MSK[i]);
        end
      end
      if (wr_addr == `VDCR_OFS_PWR_RST && q.sh[`VDCR_BIT_SOFT_RESET])
      begin
        d.regs      = RST;
        d.srst_busy = 1'b1;
        d.srst_cnt  = 18'h0;
      end
    end
    if (q.srst_busy)
    begin
      d.srst_cnt = q.srst_cnt + 18'h1;
      if (q.srst_cnt == SRST_LAST)
      begin
        d.srst_busy = 1'b0;
      end
    end

    // Sticky lost lock: a new loss beats a clearing read
    d.lock_prev = status_i.in_lock;
    if (rd_load && main_map && q.ptr == `VDCR_OFS_LOCK_STAT)
    begin
      d.lost_lock = 1'b0;
    end
    if (q.lock_prev && !status_i.in_lock)
    begin
      d.lost_lock = 1'b1;
    end

    // Delay alignment, automatic values follow the input format
    if (q.regs[S_DLY][`VDCR_BIT_AUTO_ALIGN])
    begin
      unique case (input_format_i)
        2'h0:    {d.luma_delay, d.chroma_delay} = {2'h0, 3'h3};
        2'h1:    {d.luma_delay, d.chroma_delay} = {2'h1, 3'h5};
        default: {d.luma_delay, d.chroma_delay} = {2'h1, 3'h6};
      endcase
    end
    else
    begin
      d.luma_delay   = q.regs[S_DLY][1:0];
      d.chroma_delay = q.regs[S_DLY][5:3];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      q              <= '0;
      q.scl_sync     <= 3'h7;
      q.sda_sync     <= 3'h7;
      q.st           <= vdcr_pkg::VDCR_ST_IDLE;
      q.regs         <= RST;
      q.chroma_delay <= 3'h3;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_o                       = 1'b0;
  assign sda_oe_o                    = q.sda_oe;
  assign soft_reset_busy_o           = q.srst_busy;
  assign luma_delay_o                = q.luma_delay;
  assign chroma_delay_o              = q.chroma_delay;
  assign ctrl_o.default_cr           = q.regs[S_CHR][7:4];
  assign ctrl_o.default_cb           = q.regs[S_CHR][3:0];
  assign ctrl_o.submap_select        = q.regs[S_MAP][6:5];
  assign ctrl_o.power_down_bit       =
    q.regs[S_PWR][`VDCR_BIT_POWER_DOWN];
  assign ctrl_o.free_run_pattern     = q.regs[S_CLP][2:0];
  assign ctrl_o.current_clamp_on     = q.regs[S_CLP][4];
  assign ctrl_o.digital_clamp_freeze = q.regs[S_DCL][4];
  assign ctrl_o.digital_clamp_speed  = q.regs[S_DCL][6:5];
  assign ctrl_o.luma_shape_filter    = q.regs[S_SHP][4:0];
  assign ctrl_o.chroma_shape_filter  = q.regs[S_SHP][7:5];
  assign ctrl_o.wide_luma_filter     = q.regs[S_WID][4:0];
  assign ctrl_o.wide_filter_manual   = q.regs[S_WID][7];
  assign ctrl_o.pal_comb_bandwidth   = q.regs[S_CMB][1:0];
  assign ctrl_o.ntsc_comb_bandwidth  = q.regs[S_CMB][3:2];
  assign ctrl_o.llc_tristate         = q.regs[S_PIN][7];
  assign ctrl_o.auto_delay_align     =
    q.regs[S_DLY][`VDCR_BIT_AUTO_ALIGN];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_srst_hold;
    soft_reset_busy_o [*4];
  endsequence
  property p_srst_defaults;
    $rose(soft_reset_busy_o) |-> ctrl_o.default_cr == 4'h7 &&
      ctrl_o.default_cb == 4'hc && !ctrl_o.power_down_bit ##0 s_srst_hold;
  endproperty
  a_srst_defaults: assert property (p_srst_defaults)
    else $error("soft reset did not restore defaults");

  property p_lost_lock;
    $fell(status_i.in_lock) |=> q.lost_lock;
  endproperty
  a_lost_lock: assert property (p_lost_lock)
    else $error("lost lock not latched");

  property p_lost_hold;
    q.lost_lock && !rd_load |=> q.lost_lock;
  endproperty
  a_lost_hold: assert property (p_lost_hold)
    else $error("lost lock dropped without a read");

  property p_submap_read;
    rd_load && !main_map && q.ptr != `VDCR_OFS_MAP_SEL |=> q.sh == 8'h00;
  endproperty
  a_submap_read: assert property (p_submap_read)
    else $error("other submap read leaked main data");

  property p_rev_id;
    rd_load && main_map && q.ptr == `VDCR_OFS_REV_ID |=> q.sh == REV_ID;
  endproperty
  a_rev_id: assert property (p_rev_id)
    else $error("revision identifier wrong");

  property p_auto_cvbs;
    ctrl_o.auto_delay_align && input_format_i == 2'h0 |=>
      luma_delay_o == 2'h0 && chroma_delay_o == 3'h3;
  endproperty
  a_auto_cvbs: assert property (p_auto_cvbs)
    else $error("automatic delay not applied");

  property p_manual_delay;
    !ctrl_o.auto_delay_align |=> luma_delay_o == $past(q.regs[S_DLY][1:0])
      && chroma_delay_o == $past(q.regs[S_DLY][5:3]);
  endproperty
  a_manual_delay: assert property (p_manual_delay)
    else $error("programmed delay not applied");

  property p_srst_write_block;
    soft_reset_busy_o |=> $stable(ctrl_o) || $rose(soft_reset_busy_o);
  endproperty
  a_srst_write_block: assert property (p_srst_write_block)
    else $error("control changed during reset sequence");

endmodule

// [testbench/vdcr_host_model.sv]
// Two-wire host model: drives SCL, pulls SDA low
// Assumes a pull-up on SDA and the device only pulling low
`timescale 1ns/1ps

module vdcr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  // Clock
  input  wire logic clk_i,
  // Bus
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic host_low = 1'b0;
  initial scl_o = 1'b1;
  // Released line floats to the pull-up level
  assign sda_o = ~(host_low | sda_oe_i);

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Eight clocks a phase: four times the minimum, margin for the syncs
  task automatic ph();
    repeat (8) @(posedge clk_i);
  endtask

  task automatic cond(input logic is_stop);
    host_low <= is_stop;
    ph();
    scl_o <= 1'b1;
    ph();
    host_low <= ~is_stop;
    ph();
    if (!is_stop)
    begin
      scl_o <= 1'b0;
      ph();
    end
  endtask

  task automatic bx(input logic b, output logic r);
    host_low <= ~b;
    ph();
    scl_o <= 1'b1;
    ph();
    r = sda_o;
    scl_o <= 1'b0;
    ph();
  endtask

  task automatic by(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      bx(d[i], r[i]);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] a, v,
                    output logic ok);
    logic [7:0] r;
    logic [2:0] k;
    cond(1'b0);
    by({dev, 1'b0}, r);
    bx(1'b1, k[0]);
    by(a, r);
    bx(1'b1, k[1]);
    by(v, r);
    bx(1'b1, k[2]);
    cond(1'b1);
    ok = (k == 3'h0);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [7:0] r;
    logic       k;
    cond(1'b0);
    by({DEV_ADDR, 1'b0}, r);
    bx(1'b1, k);
    by(a, r);
    bx(1'b1, k);
    cond(1'b0);
    by({DEV_ADDR, 1'b1}, r);
    bx(1'b1, k);
    by(8'hff, v);
    // Not-acknowledge: one byte per read
    bx(1'b1, k);
    cond(1'b1);
  endtask
endmodule

// [testbench/vdcr_top_tb.sv]
// Self-checking bench for the decoder control register bank
// Assumes the host model is the only master on the port
`timescale 1ns/1ps

module vdcr_top_tb;
  // Short soft reset keeps the run small; REV value is arbitrary
  localparam int          SRST = 200;
  localparam logic [7:0]  REV  = 8'h6b;
  localparam logic [6:0]  ADDR = 7'h2c;
  localparam logic [15:0] RST [10] = '{16'h0d7c, 16'h0e00, 16'h0f00,
    16'h1410, 16'h1500, 16'h1701, 16'h1893, 16'h19f1, 16'h1d40, 16'h2758};
  localparam logic [23:0] WT [9] = '{24'h0da5a5, 24'h0f2020, 24'h141515,
    24'h157070, 24'h17ffff, 24'h188585, 24'h190efe, 24'h270b0b,
    24'h1d80c0};
  localparam logic [2:0]  PAT [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
  localparam logic [7:0]  MSK [2] = '{8'hb5, 8'h4a};

  logic                   clk_i;
  logic                   reset_i;
  logic                   scl;
  logic                   sda;
  logic                   sda_oe;
  logic                   sdo;
  logic                   busy;
  logic                   ok;
  logic [1:0]             fmt;
  logic [1:0]             ld;
  logic [2:0]             cd;
  logic [7:0]             rv;
  vdcr_pkg::vdcr_status_s st;
  vdcr_pkg::vdcr_ctrl_s   ct;
  int                     miscompares;
  int                     tests_run;
  int                     n;

  vdcr_top #(.DEV_ADDR(ADDR), .REV_ID(REV), .SRST_CYCLES(SRST)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sdo), .sda_oe_o(sda_oe), .status_i(st), .input_format_i(fmt),
    .ctrl_o(ct), .luma_delay_o(ld), .chroma_delay_o(cd),
    .soft_reset_busy_o(busy));
  vdcr_host_model #(.DEV_ADDR(ADDR)) host (.clk_i(clk_i),
    .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.wr(ADDR, a, v, ok);
    chk({7'h0, ok}, 8'h01);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    miscompares = 0;
    tests_run = 0;
    reset_i = 1'b1;
    fmt = 2'h0;
    st = '0;
    st.in_lock = 1'b1;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    foreach (RST[i])
      rc(RST[i][15:8], RST[i][7:0]);
    rc(8'h11, REV);
    rc(8'h16, 8'h00);
    chk({ld, 3'h0, cd}, 8'h03);
    foreach (PAT[k])
    begin
      wr(8'h14, {5'h02, PAT[k]});
      wr(8'h15, {1'b0, 2'(k), 5'h10});
      chk({ct.free_run_pattern, ct.digital_clamp_speed,
        ct.current_clamp_on, ct.digital_clamp_freeze, 1'b0},
        {PAT[k], 2'(k), 3'h6});
    end
    foreach (WT[i])
    begin
      wr(WT[i][23:16], WT[i][15:8]);
      rc(WT[i][23:16], WT[i][7:0]);
    end
    chk({ct.default_cr, ct.default_cb}, 8'ha5);
    chk({7'h0, ct.power_down_bit}, 8'h01);
    chk({7'h0, ct.llc_tristate}, 8'h01);
    chk({7'h0, sdo}, 8'h00);
    chk({ct.chroma_shape_filter, ct.luma_shape_filter}, 8'hff);
    chk({ct.wide_filter_manual, 2'h0, ct.wide_luma_filter}, 8'h85);
    chk({4'h0, ct.ntsc_comb_bandwidth, ct.pal_comb_bandwidth}, 8'h0e);
    chk({ld, 3'h0, cd}, 8'hc1);
    wr(8'h27, 8'h40);
    for (int f = 1; f < 4; f++)
    begin
      @(posedge clk_i);
      fmt <= 2'(f);
      repeat (3) @(negedge clk_i);
      chk({ld, 3'h0, cd}, (f == 1) ? 8'h45 : 8'h46);
    end
    // Wrong device address must leave the bank untouched
    host.wr(7'h2d, 8'h0d, 8'h11, ok);
    chk({7'h0, ok}, 8'h00);
    rc(8'h0d, 8'ha5);
    wr(8'h0e, 8'h20);
    chk({6'h0, ct.submap_select}, 8'h01);
    rc(8'h0d, 8'h00);
    wr(8'h0e, 8'h40);
    chk({6'h0, ct.submap_select}, 8'h02);
    wr(8'h0e, 8'h00);
    rc(8'h0d, 8'ha5);
    st.in_lock <= 1'b0;
    repeat (4) @(posedge clk_i);
    st.in_lock <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      {st.subcarrier_lock, st.peak_white_gain_active, st.color_kill} <= 3'(i);
      st.standard <= 3'(i);
      host.rd(8'h10, rv);
      chk(rv, {i[0], 3'(i), i[1], i[2], i == 0, 1'b1});
    end
    foreach (MSK[j])
    begin
      {st.odd_subcarrier, st.odd_line_length, st.agc_pulse_detected,
        st.pseudosync_detected, st.stripe_type, st.stripe_detected}
        <= MSK[j][5:0];
      {st.swinging_burst_lock, st.interlaced, st.field_length_ok,
        st.free_run_active} <= MSK[j][7:4];
      {st.field_rate_fifty, st.raw_horizontal_lock} <= {MSK[j][2], MSK[j][0]};
      rc(8'h12, {2'h0, MSK[j][5:0]});
      rc(8'h13, MSK[j] & 8'hf5);
    end
    n = 0;
    fork
      wr(8'h0f, 8'h80);
      for (int c = 0; c < 4000 && !(n > 0 && busy === 1'b0); c++)
      begin
        @(negedge clk_i);
        if (busy === 1'b1)
          n++;
      end
    join
    chk(8'(n), 8'(SRST));
    chk({ct.default_cr, ct.default_cb}, 8'h7c);
    rc(8'h0f, 8'h00);
    rc(8'h27, 8'h58);
    end_of_test();
  end
endmodule
